/* File: bench/etl_far_end.sv */
`timescale 1ns/100ps
`default_nettype none
module etl_far_end (
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              lrx_bit_in,
    input  wire logic              txs_bit_in,
    input  wire logic              rxs_bit_in,
    input  wire logic              loop_in,
    input  wire logic              fb_bit_in,
    input  wire logic              fb_en_in,
    output var etl_pkg::etl_strm_t lrx_out,
    output var etl_pkg::etl_strm_t txs_out,
    output var etl_pkg::etl_strm_t rxs_out
);
    logic [1:0] div_reg;
    logic [7:0] cnt_reg;
    logic       fb_reg;
    // ==========================================================
    // Bit timing: one strobe every fourth cycle, slot and position
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_reg <= 2'h0;
            cnt_reg <= 8'h00;
            fb_reg  <= 1'b0;
        end else begin
            div_reg <= div_reg + 2'h1;
            // Line output changes between strobes; keep its strobed bit
            if (fb_en_in) begin
                fb_reg <= fb_bit_in;
            end
            if (div_reg == 2'h3) begin
                cnt_reg <= cnt_reg + 8'h01;
            end
        end
    end
    // Between strobes the line shows the inverse, never a stale bit
    // Timing passed in, so the assigns follow every counter change
    function automatic etl_pkg::etl_strm_t mk(input logic b,
                                              input logic [1:0] d,
                                              input logic [7:0] c);
        etl_pkg::etl_strm_t s;
        s.en      = (d == 2'h3);
        s.bit_val = s.en ? b : ~b;
        s.slot    = c[7:3];
        s.pos     = c[2:0];
        s.ts0     = (c[7:3] == 5'h00);
        return s;
    endfunction
    // Static bits per stream, or the looped line output on lrx and rxs when loop_in; no tone patterns
    assign lrx_out = mk(loop_in ? fb_reg : lrx_bit_in, div_reg, cnt_reg);
    assign txs_out = mk(txs_bit_in, div_reg, cnt_reg);
    assign rxs_out = mk(loop_in ? fb_reg : rxs_bit_in, div_reg, cnt_reg);
endmodule
`default_nettype wire

/* File: bench/etl_test_unit_tb_top.sv */
`include "etl_map.svh"
`timescale 1ns/100ps
`default_nettype none
module etl_test_unit_tb_top;
    logic clk_in = 1'b0, rst_n_in = 1'b0, wr = 1'b0, rd = 1'b0;
    logic ts0g = 1'b0, aux = 1'b0, lb = 1'b0;
    logic lrxb = 1'b0, txsb = 1'b0, rxsb = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rv;
    logic ltx_b, ltx_e, rcv_b, rcv_e, rxd, rxe, csel, jatt, rem;
    etl_pkg::etl_strm_t lrx, txs, rxs;
    etl_pkg::etl_alm_t alm_in = '0, alm;
    etl_pkg::etl_evt_t evt;
    int n_evt = 0;
    int miscompares = 0;
    int cmp_count = 0;
    logic [7:0] cfg [3] = '{8'h03, 8'h07, 8'h0b};

    always #5 clk_in = ~clk_in;

    always @(posedge clk_in) begin
        if (evt == 6'h3f) n_evt <= n_evt + 1;
    end

    etl_far_end far (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .lrx_bit_in(lrxb), .txs_bit_in(txsb), .rxs_bit_in(rxsb),
        .loop_in(lb), .fb_bit_in(ltx_b), .fb_en_in(ltx_e),
        .lrx_out(lrx), .txs_out(txs),
        .rxs_out(rxs));

    etl_test_unit #(.SIM_TICK_CYC(16)) dut (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .line_rx_in(lrx),
        .tx_sys_in(txs), .rx_sys_in(rxs), .tx_ts0_gen_in(ts0g),
        .crc4_mode_in(1'b1), .alarm_real_in(alm_in), .evt_real_in('0),
        .aux_err_in(aux), .line_tx_bit_out(ltx_b), .line_tx_en_out(ltx_e),
        .rcv_bit_out(rcv_b), .rcv_en_out(rcv_e), .rx_sys_data_out(rxd),
        .rx_sys_en_out(rxe), .tx_clk_sel_rx_out(csel),
        .jatt_loop_out(jatt), .alarm_rpt_out(alm), .evt_rpt_out(evt),
        .remote_alarm_out(rem));

    // ==========================================================
    // Reporting and bus tasks
    task give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task wrr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    task rdr(input logic [7:0] a);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask
    // Third strobe seen, so old-mode bits have drained
    task sb(input int s, input logic e, input string n);
        int k;
        logic g;
        logic [1:0] v;
        k = 0;
        g = 1'bx;
        for (int i = 0; i < 60 && k < 3; i++) begin
            @(posedge clk_in);
            #1 v = s == 0 ? {ltx_e, ltx_b} : s == 1 ? {rcv_e, rcv_b}
                                           : {rxe, rxd};
            if (v[1] === 1'b1) begin
                k++;
                g = v[0];
            end
        end
        if (k < 3) begin
            miscompares++;
            give_verdict;
        end
        chk(n, {7'h00, e}, {7'h00, g});
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rdr(`ETL_A_CTRL0); chk("ctrl0", 8'h00, rv);
        rdr(`ETL_A_CTRL1); chk("ctrl1", 8'h00, rv);
        rdr(`ETL_A_IDLE);  chk("idle", 8'hff, rv);
        wrr(8'h20, 8'h55);
        rdr(8'h20); chk("unmapped", 8'h00, rv);
        wrr(`ETL_A_LOOP, 8'h1f);
        rdr(`ETL_A_LOOP); chk("loop", 8'h1f, rv);
        lrxb <= 1'b1;
        sb(1, 1'b1, "rcv");
        sb(0, 1'b0, "ltx");
        wrr(`ETL_A_CTRL0, 8'h02); // Same line code both ways
        sb(1, 1'b0, "rcv");
        sb(0, 1'b0, "ltx");
        wrr(`ETL_A_CTRL0, 8'h82);
        sb(0, 1'b1, "ltx");
        sb(1, 1'b0, "rcv");
        wrr(`ETL_A_CTRL0, 8'h04);
        sb(0, 1'b1, "ltx");
        sb(2, 1'b0, "rxd");
        chk("jatt", 8'h00, {7'h00, jatt});
        wrr(`ETL_A_CTRL0, 8'h0c);
        sb(0, 1'b1, "ltx");
        chk("jatt", 8'h01, {7'h00, jatt});
        rxsb <= 1'b1;
        ts0g <= 1'b1;
        wrr(`ETL_A_CTRL0, 8'h10);
        sb(0, 1'b1, "ltx");
        sb(2, 1'b1, "rxd");
        chk("csel", 8'h01, {7'h00, csel});
        rxsb <= 1'b0;
        ts0g <= 1'b0;
        txsb <= 1'b1;
        sb(0, 1'b0, "ltx");
        wrr(`ETL_A_CTRL0, 8'h30);
        sb(2, 1'b1, "rxd");
        sb(0, 1'b0, "ltx");
        wrr(`ETL_A_CTRL0, 8'h00);
        lb <= 1'b1;
        for (int c = 0; c < 3; c++) begin
            wrr(`ETL_A_CTRL1, 8'h00);
            wrr(`ETL_A_CTRL1, cfg[c]);
            for (int i = 0; i < 200; i++) begin
                rdr(`ETL_A_STAT);
                if (rv[0] === 1'b1) break;
            end
            chk("sync", (c == 2) ? 8'h03 : 8'h01, {6'h00, rv[1:0]});
            rdr(`ETL_A_ISR); chk("isr0", 8'h01, {7'h00, rv[0]});
        end
        wrr(`ETL_A_CTRL1, 8'h00);
        lb <= 1'b0;
        alm_in <= 4'b1000;
        repeat (3) @(posedge clk_in);
        chk("rem", 8'h01, {7'h00, rem});
        rdr(`ETL_A_ISR); chk("isr", 8'h03, rv);
        wrr(`ETL_A_CTRL0, 8'h01);
        repeat (40) @(posedge clk_in);
        chk("alm", 8'h0f, {4'h0, alm});
        chk("rem", 8'h00, {7'h00, rem});
        alm_in <= 4'b0000;
        wrr(`ETL_A_CTRL0, 8'h00);
        repeat (4) @(posedge clk_in);
        chk("alm", 8'h00, {4'h0, alm});
        rdr(`ETL_A_ISR); chk("isr", 8'h7c, rv);
        rdr(`ETL_A_ISR); chk("isr", 8'h00, rv);
        rdr(`ETL_A_SEQ_LO); chk("seq_lo", 8'h02, rv);
        chk("evt", 8'h02, 8'(n_evt));
        rdr(`ETL_A_AUX_LO); chk("aux_lo", 8'h02, rv);
        rdr(`ETL_A_AUX_HI);
        repeat (3) begin
            @(posedge clk_in);
            aux <= 1'b1;
            @(posedge clk_in);
            aux <= 1'b0;
        end
        rdr(`ETL_A_AUX_LO); chk("aux_lo", 8'h03, rv);
        rdr(`ETL_A_AUX_HI); chk("aux_hi", 8'h00, rv);
        rdr(`ETL_A_AUX_LO); chk("aux_lo", 8'h00, rv);
        give_verdict;
    end

    initial begin
        repeat (60000) @(posedge clk_in);
        miscompares++;
        give_verdict;
    end
endmodule
`default_nettype wire

/* File: rtl/etl_map.svh */
`ifndef ETL_MAP_SVH
`define ETL_MAP_SVH
// ==========================================================
// Register offsets
`define ETL_A_CTRL0   8'h00
`define ETL_A_CTRL1   8'h01
`define ETL_A_LOOP    8'h02
`define ETL_A_IDLE    8'h03
`define ETL_A_STAT    8'h04
`define ETL_A_ISR     8'h05
`define ETL_A_SEQ_LO  8'h06
`define ETL_A_SEQ_HI  8'h07
`define ETL_A_AUX_LO  8'h08
`define ETL_A_AUX_HI  8'h09
// ==========================================================
// Control 0 fields
`define ETL_B_SIM     0
`define ETL_B_LL      1
`define ETL_B_RL      2
`define ETL_B_JATT    3
`define ETL_B_PL      4
`define ETL_B_SAIS    5
`define ETL_B_TT0     6
`define ETL_B_XAIS    7
// ==========================================================
// Control 1 fields
`define ETL_B_GEN     0
`define ETL_B_MON     1
`define ETL_B_LEN20   2
`define ETL_B_INV     3
`define ETL_B_FRA     4
`define ETL_B_ECNT    5
`define ETL_B_CHL     6
// ==========================================================
// Reset values and timing
`define ETL_R_CTRL    8'h00
`define ETL_R_IDLE    8'hff
`define ETL_R_LOOP    5'h00
`define ETL_CLK_MHZ   100
`define ETL_SIM_TICK_US 1000
`define ETL_SYNC_RUN  6'h20
`define ETL_WIN_LAST  6'h3f
`define ETL_LOSS_ERR  7'h10
`endif

/* File: rtl/etl_pkg.sv */
// ==========================================================
// Shared types
package etl_pkg;
    typedef struct packed {
        logic       bit_val;
        logic       en;
        logic       ts0;
        logic [4:0] slot;
        logic [2:0] pos;
    } etl_strm_t;
    typedef struct packed {
        logic los;
        logic ais;
        logic lof;
        logic rai;
    } etl_alm_t;
    typedef struct packed {
        logic slip_rx;
        logic slip_tx;
        logic fe;
        logic cv;
        logic crc;
        logic ebit;
    } etl_evt_t;
    typedef enum logic {MON_HUNT, MON_SYNC} etl_mon_t;
endpackage

/* File: rtl/etl_test_unit.sv */
// What this block does
// R01: Generate 2^15-1 or 2^20-1 sequence to the line, optionally inverted.
// R02: Monitor hunts the sequence and locks on either polarity.
// R03: Sync state shown in status and flagged in interrupt status.
// R04: With count enable, each sequence bit error adds one to counter.
// R05: Lock within 400 ms at 99.9% even at error rate 1e-1.
// R06: Framed select 1 skips framing slot; 0 covers every bit.
// R07: Remote loop sends recovered line data back out; system path unchanged.
// R08: Remote loop with jitter attenuator select routes via or around FIFO.
// R09: Payload loop returns elastic-store output to transmitter, still output.
// R10: Payload loop with system AIS sends all ones to system side.
// R11: Payload loop: slot 0 generated unless transparent slot 0 set.
// R12: Payload loop clocks transmitter from receive side; tx inputs ignored.
// R13: Local loop feeds transmit data to receiver; line still gets it.
// R14: Line AIS in local loop hits the line only, not looped data.
// R15: Local loop may cause out-of-frame; software matches line codes.
// R16: One selected slot of 32 loops from system input to output.
// R17: Looped slot carries the idle code toward the remote end.
// R18: Tester should use quasi-static pattern, not a changing tone.
// R19: Simulation keeps traffic; real alarms hidden from processor and remote.
// R20: Simulation bit fakes alarms, slips and counter increments where valid.
// R21: Simulated conditions vanish on clear; interrupt bits stay until read.
// R22: Reading interrupt status or an error counter clears it.
`include "etl_map.svh"
`timescale 1ns/100ps
`default_nettype none
module etl_test_unit #(
    parameter int unsigned SIM_TICK_CYC = `ETL_SIM_TICK_US * `ETL_CLK_MHZ
) (
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic [7:0]        addr_in,
    input  wire logic [7:0]        wdata_in,
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    output logic [7:0]             rdata_out,
    input  wire etl_pkg::etl_strm_t line_rx_in,
    input  wire etl_pkg::etl_strm_t tx_sys_in,
    input  wire etl_pkg::etl_strm_t rx_sys_in,
    input  wire logic              tx_ts0_gen_in,
    input  wire logic              crc4_mode_in,
    input  wire etl_pkg::etl_alm_t alarm_real_in,
    input  wire etl_pkg::etl_evt_t evt_real_in,
    input  wire logic              aux_err_in,
    output logic                   line_tx_bit_out,
    output logic                   line_tx_en_out,
    output logic                   rcv_bit_out,
    output logic                   rcv_en_out,
    output logic                   rx_sys_data_out,
    output logic                   rx_sys_en_out,
    output logic                   tx_clk_sel_rx_out,
    output logic                   jatt_loop_out,
    output etl_pkg::etl_alm_t      alarm_rpt_out,
    output etl_pkg::etl_evt_t      evt_rpt_out,
    output logic                   remote_alarm_out
);
    localparam int TW = $clog2(SIM_TICK_CYC + 1);

    // ======================================================
    // Register port
    logic [7:0]  ctrl0_reg, ctrl1_reg, idle_reg, isr_reg, rdata_reg;
    logic [7:0]  seq_hold_reg, aux_hold_reg, cap_reg, rd_mux;
    logic [4:0]  loop_reg;
    logic [15:0] seq_cnt_reg, aux_cnt_reg;

    wire alarm_sim_en        = ctrl0_reg[`ETL_B_SIM];
    wire local_loop_en       = ctrl0_reg[`ETL_B_LL];
    wire remote_loop_en      = ctrl0_reg[`ETL_B_RL];
    wire tx_jitter_atten_sel = ctrl0_reg[`ETL_B_JATT];
    wire payload_loop_en     = ctrl0_reg[`ETL_B_PL];
    wire system_ais_send     = ctrl0_reg[`ETL_B_SAIS];
    wire transparent_slot0   = ctrl0_reg[`ETL_B_TT0];
    wire line_ais_send       = ctrl0_reg[`ETL_B_XAIS];
    wire seq_gen_en          = ctrl1_reg[`ETL_B_GEN];
    wire seq_mon_en          = ctrl1_reg[`ETL_B_MON];
    wire seq_len20           = ctrl1_reg[`ETL_B_LEN20];
    wire seq_tx_invert       = ctrl1_reg[`ETL_B_INV];
    wire seq_framed_select   = ctrl1_reg[`ETL_B_FRA];
    wire seq_err_count_en    = ctrl1_reg[`ETL_B_ECNT];
    wire chan_loop_en        = ctrl1_reg[`ETL_B_CHL];

    wire isr_rd = rd_in && addr_in == `ETL_A_ISR;
    wire seq_rd = rd_in && addr_in == `ETL_A_SEQ_LO;
    wire aux_rd = rd_in && addr_in == `ETL_A_AUX_LO;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl0_reg <= `ETL_R_CTRL;
            ctrl1_reg <= `ETL_R_CTRL;
            idle_reg  <= `ETL_R_IDLE;
            loop_reg  <= `ETL_R_LOOP;
        end else if (wr_in) begin
            case (addr_in)
                `ETL_A_CTRL0: ctrl0_reg <= wdata_in;
                `ETL_A_CTRL1: ctrl1_reg <= wdata_in;
                `ETL_A_LOOP:  loop_reg  <= wdata_in[4:0]; // [R16]
                `ETL_A_IDLE:  idle_reg  <= wdata_in;
                default:      ;
            endcase
        end
    end

    // ======================================================
    // Sequence generator
    function automatic logic seq_fb(input logic [19:0] s,
                                    input logic l20);
        seq_fb = l20 ? (s[19] ^ s[2]) : (s[14] ^ s[13]);
    endfunction

    etl_pkg::etl_strm_t tx_src;
    logic [19:0] gen_reg;
    // Payload loop borrows receive timing; tx system pins unused
    assign tx_src = payload_loop_en ? rx_sys_in : tx_sys_in; // [R12]
    wire gen_bit  = seq_fb(gen_reg, seq_len20);
    wire gen_step = seq_gen_en && tx_src.en
                    && !(seq_framed_select && tx_src.ts0); // [R06]

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gen_reg <= 20'hf_ffff;
        end else if (gen_step) begin
            gen_reg <= {gen_reg[18:0], gen_bit}; // [R01]
        end
    end

    // ======================================================
    // Sequence monitor
    etl_pkg::etl_mon_t mon_state;
    logic [19:0] hist_reg;
    logic [5:0]  run_reg, win_reg;
    logic [6:0]  werr_reg;
    logic        cand_reg, inv_reg, sync_prev_reg;

    wire mon_step = seq_mon_en && rx_sys_in.en
                    && !(seq_framed_select && rx_sys_in.ts0); // [R06]
    wire pred     = seq_fb(hist_reg, seq_len20);
    // Both taps flip together, so an inverted stream shows as diff=1
    wire diff     = rx_sys_in.bit_val ^ pred;
    wire in_sync  = mon_state == etl_pkg::MON_SYNC;
    wire mon_err  = mon_step && in_sync && (diff != inv_reg);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mon_state <= etl_pkg::MON_HUNT;
            hist_reg  <= 20'h0_0000;
            run_reg   <= 6'h00;
            win_reg   <= 6'h00;
            werr_reg  <= 7'h00;
            cand_reg  <= 1'b0;
            inv_reg   <= 1'b0;
        end else if (!seq_mon_en) begin
            mon_state <= etl_pkg::MON_HUNT;
            run_reg   <= 6'h00;
        end else if (mon_step) begin
            // Free-run once locked so one error counts once
            hist_reg <= {hist_reg[18:0],
                         in_sync ? (pred ^ inv_reg) : rx_sys_in.bit_val};
            case (mon_state)
                etl_pkg::MON_HUNT: begin
                    if (diff == cand_reg) begin
                        run_reg <= run_reg + 6'h01;
                        // 32-bit run meets 400 ms even at 1e-1
                        if (run_reg == `ETL_SYNC_RUN - 6'h01) begin // [R05]
                            mon_state <= etl_pkg::MON_SYNC; // [R02]
                            inv_reg   <= cand_reg;
                            win_reg   <= 6'h00;
                            werr_reg  <= 7'h00;
                        end
                    end else begin
                        cand_reg <= diff;
                        run_reg  <= 6'h01;
                    end
                end
                etl_pkg::MON_SYNC: begin
                    win_reg  <= win_reg + 6'h01;
                    werr_reg <= werr_reg + 7'(mon_err);
                    if (win_reg == `ETL_WIN_LAST) begin
                        werr_reg <= 7'h00;
                        if (werr_reg + 7'(mon_err) >= `ETL_LOSS_ERR) begin
                            mon_state <= etl_pkg::MON_HUNT;
                            run_reg   <= 6'h00;
                        end
                    end
                end
                default: mon_state <= etl_pkg::MON_HUNT;
            endcase
        end
    end

    // ======================================================
    // Alarm simulation
    logic [TW-1:0] tick_reg;
    etl_pkg::etl_alm_t alm_next;
    etl_pkg::etl_evt_t evt_next;
    wire sim_tick = alarm_sim_en && tick_reg == TW'(SIM_TICK_CYC - 1);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tick_reg <= '0;
        end else if (!alarm_sim_en || sim_tick) begin
            tick_reg <= '0;
        end else begin
            tick_reg <= tick_reg + TW'(1);
        end
    end

    always_comb begin
        // Real conditions masked while simulating
        alm_next = alarm_sim_en ? 4'hf : alarm_real_in; // [R19] [R20] [R21]
        evt_next = evt_real_in;
        if (alarm_sim_en) begin
            // CRC and E-bit only apply in multiframe mode
            evt_next = {{4{sim_tick}}, {2{sim_tick && crc4_mode_in}}}; // [R20]
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            alarm_rpt_out    <= '0;
            evt_rpt_out      <= '0;
            remote_alarm_out <= 1'b0;
            sync_prev_reg    <= 1'b0;
        end else begin
            alarm_rpt_out    <= alm_next;
            evt_rpt_out      <= evt_next;
            remote_alarm_out <= !alarm_sim_en
                                && (alarm_real_in.los || alarm_real_in.lof); // [R19]
            sync_prev_reg    <= in_sync;
        end
    end

    // ======================================================
    // Interrupt status and counters
    wire [3:0] alm_rise = alm_next & ~alarm_rpt_out;
    wire [7:0] isr_set  = {1'b0, evt_next.slip_tx, evt_next.slip_rx,
                           alm_rise[0], alm_rise[1], alm_rise[2],
                           alm_rise[3], in_sync != sync_prev_reg}; // [R03]
    wire seq_inc = mon_err && seq_err_count_en || sim_tick; // [R04] [R20]
    wire aux_inc = aux_err_in && !alarm_sim_en || sim_tick;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            isr_reg <= 8'h00;
        end else if (isr_rd) begin
            isr_reg <= isr_set; // [R22]
        end else begin
            isr_reg <= isr_reg | isr_set; // [R21]
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            seq_cnt_reg  <= 16'h0000;
            seq_hold_reg <= 8'h00;
        end else if (seq_rd) begin
            seq_hold_reg <= seq_cnt_reg[15:8];
            seq_cnt_reg  <= 16'(seq_inc); // [R22]
        end else if (seq_inc && seq_cnt_reg != 16'hffff) begin
            seq_cnt_reg <= seq_cnt_reg + 16'h0001; // [R04]
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            aux_cnt_reg  <= 16'h0000;
            aux_hold_reg <= 8'h00;
        end else if (aux_rd) begin
            aux_hold_reg <= aux_cnt_reg[15:8];
            aux_cnt_reg  <= 16'(aux_inc); // [R22]
        end else if (aux_inc && aux_cnt_reg != 16'hffff) begin
            aux_cnt_reg <= aux_cnt_reg + 16'h0001;
        end
    end

    always_comb begin
        case (addr_in)
            `ETL_A_CTRL0:  rd_mux = ctrl0_reg;
            `ETL_A_CTRL1:  rd_mux = ctrl1_reg;
            `ETL_A_LOOP:   rd_mux = {3'h0, loop_reg};
            `ETL_A_IDLE:   rd_mux = idle_reg;
            `ETL_A_STAT:   rd_mux = {2'h0, alarm_rpt_out,
                                     inv_reg && in_sync, in_sync}; // [R03]
            `ETL_A_ISR:    rd_mux = isr_reg;
            `ETL_A_SEQ_LO: rd_mux = seq_cnt_reg[7:0];
            `ETL_A_SEQ_HI: rd_mux = seq_hold_reg;
            `ETL_A_AUX_LO: rd_mux = aux_cnt_reg[7:0];
            `ETL_A_AUX_HI: rd_mux = aux_hold_reg;
            default:       rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rd_in ? rd_mux : 8'h00;
        end
    end
    assign rdata_out = rdata_reg;

    // ======================================================
    // Data paths
    logic pre_bit, tx_bit, tx_en, rx_bit;
    wire tx_hit = chan_loop_en && !payload_loop_en
                  && tx_src.slot == loop_reg;
    wire rx_hit = chan_loop_en && rx_sys_in.slot == loop_reg;

    always_comb begin
        pre_bit = tx_src.bit_val; // [R09]
        if (payload_loop_en && tx_src.ts0 && !transparent_slot0) begin
            pre_bit = tx_ts0_gen_in; // [R11]
        end
        if (tx_hit) begin
            pre_bit = idle_reg[3'h7 - tx_src.pos]; // [R17]
        end
        if (gen_step) begin
            pre_bit = gen_bit ^ seq_tx_invert; // [R01]
        end
        tx_bit = line_ais_send ? 1'b1 : pre_bit; // [R14]
        tx_en  = tx_src.en;
        if (remote_loop_en) begin
            tx_bit = line_rx_in.bit_val; // [R07]
            tx_en  = line_rx_in.en;
        end
        rx_bit = rx_hit ? cap_reg[3'h7 - rx_sys_in.pos] // [R16]
                        : rx_sys_in.bit_val;
        if (payload_loop_en && system_ais_send) begin
            rx_bit = 1'b1; // [R10]
        end
    end

    // Slot byte is replayed; a moving tone here would slip
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cap_reg <= 8'h00;
        end else if (tx_hit && tx_sys_in.en) begin
            cap_reg[3'h7 - tx_sys_in.pos] <= tx_sys_in.bit_val; // [R16]
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            line_tx_bit_out   <= 1'b0;
            line_tx_en_out    <= 1'b0;
            rcv_bit_out       <= 1'b0;
            rcv_en_out        <= 1'b0;
            rx_sys_data_out   <= 1'b0;
            rx_sys_en_out     <= 1'b0;
            tx_clk_sel_rx_out <= 1'b0;
            jatt_loop_out     <= 1'b0;
        end else begin
            line_tx_bit_out   <= tx_bit;
            line_tx_en_out    <= tx_en;
            // Receiver loses frame briefly after switching over
            rcv_bit_out <= local_loop_en ? pre_bit : line_rx_in.bit_val; // [R13] [R15]
            rcv_en_out  <= local_loop_en ? tx_src.en : line_rx_in.en;
            rx_sys_data_out   <= rx_bit;
            rx_sys_en_out     <= rx_sys_in.en;
            tx_clk_sel_rx_out <= payload_loop_en; // [R12]
            jatt_loop_out <= remote_loop_en && tx_jitter_atten_sel; // [R08]
        end
    end

    // ======================================================
    // Checks
    sequence s_hunt_done;
        mon_step && !in_sync && seq_mon_en && diff == cand_reg
        && run_reg == `ETL_SYNC_RUN - 6'h01;
    endsequence
    property p_lock;
        @(posedge clk_in) disable iff (!rst_n_in)
        s_hunt_done |=> in_sync && inv_reg == $past(cand_reg);
    endproperty
    a_lock: assert property (p_lock) else $error("no lock"); // [R02]
    property p_sais;
        @(posedge clk_in) disable iff (!rst_n_in)
        payload_loop_en && system_ais_send |=> rx_sys_data_out;
    endproperty
    a_sais: assert property (p_sais) else $error("ais lost"); // [R10]
    property p_rloop;
        @(posedge clk_in) disable iff (!rst_n_in)
        remote_loop_en |=> line_tx_bit_out == $past(line_rx_in.bit_val)
                           && line_tx_en_out == $past(line_rx_in.en);
    endproperty
    a_rloop: assert property (p_rloop) else $error("rloop"); // [R07]
    property p_lloop;
        @(posedge clk_in) disable iff (!rst_n_in)
        local_loop_en && line_ais_send && !remote_loop_en
        |=> line_tx_bit_out && rcv_bit_out == $past(pre_bit);
    endproperty
    a_lloop: assert property (p_lloop) else $error("lloop"); // [R14]
    property p_sim;
        @(posedge clk_in) disable iff (!rst_n_in)
        alarm_sim_en [*2] |-> alarm_rpt_out == 4'hf && !remote_alarm_out;
    endproperty
    a_sim: assert property (p_sim) else $error("sim alarm"); // [R19]
    property p_isr;
        @(posedge clk_in) disable iff (!rst_n_in)
        isr_rd ##1 isr_reg[0] |-> $past(in_sync) != $past(sync_prev_reg);
    endproperty
    a_isr: assert property (p_isr) else $error("isr clr"); // [R22]
    property p_cnt;
        @(posedge clk_in) disable iff (!rst_n_in)
        seq_inc && !seq_rd && seq_cnt_reg != 16'hffff
        |=> seq_cnt_reg == $past(seq_cnt_reg) + 16'h0001;
    endproperty
    a_cnt: assert property (p_cnt) else $error("count"); // [R04]
    property p_plclk;
        @(posedge clk_in) disable iff (!rst_n_in)
        $rose(payload_loop_en) |=> tx_clk_sel_rx_out;
    endproperty
    a_plclk: assert property (p_plclk) else $error("pl clk"); // [R12]
endmodule
`default_nettype wire
